// file: rso_host.sv
// Purpose: host model on the far side of the reset line
// Assumes: one clock, reset line sampled on rising edge
// Notes  : counts low pulses and keeps the last low length
`timescale 1ns/1ps
module rso_host (
    input  wire logic I_CLOCK,  // system clock
    input  wire logic i_rst_n,  // reset line from device
    output int        o_pulses, // low pulses seen
    output int        o_len     // last low length in cycles
);
    int n = 0;
    int cnt = 0;
    int last = 0;
    assign o_pulses = cnt;
    assign o_len    = last;
    // host restarts whenever the line rises again
    always @(posedge I_CLOCK) begin
        n <= i_rst_n ? 0 : n + 1;
        if (i_rst_n && n != 0) begin
            cnt  <= cnt + 1;
            last <= n;
        end
    end
endmodule // rso_host

// file: rso_pkg.sv
// Purpose : shared constants for the reset output and soft reset block
// Assumes : 40 MHz system clock, 32-bit Avalon-MM register port
// Notes   : timing figures are plain defaults, long counts are top parameters
package rso_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS      = 25;
    localparam int RESET_FILTER_NS    = 10000;
    localparam int EXT_DELAY_NS       = 10000000;
    localparam int RED_DELAY_NS       = 1000000;
    localparam int FILTER_CYCLES      = (RESET_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_DELAY_CYCLES   = (EXT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RED_DELAY_CYCLES   = (RED_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W              = 20;
    localparam int FILT_W             = 12;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [4:0] OFS_MODE_CTRL  = 5'h00;
    localparam logic [4:0] OFS_RESET_CFG  = 5'h04;
    localparam logic [4:0] OFS_STATUS     = 5'h08;
    localparam logic [4:0] OFS_GPIO_CFG   = 5'h0C;
    localparam logic [4:0] OFS_TIMER_PWM  = 5'h10;
    localparam logic [4:0] OFS_IRQ_STAT   = 5'h14;
    localparam logic [4:0] OFS_IRQ_MASK   = 5'h18;

    // reset_cfg fields
    localparam int CFG_DLY_SEL  = 0;
    localparam int CFG_THR_LO   = 1;
    localparam int CFG_NOPULSE  = 3;
    localparam int CFG_FAILSAFE = 4;
    localparam int CFG_LOCK     = 5;
    localparam logic [5:0] RESET_CFG_RST = 6'h00;
    localparam logic [2:0] GPIO_CFG_RST  = 3'h0;
    localparam logic [7:0] TIMER_PWM_RST = 8'h00;

    // irq bits
    localparam int IRQ_UV   = 0;
    localparam int IRQ_WD   = 1;
    localparam int IRQ_SOFT = 2;
    localparam int IRQ_REL  = 3;
    localparam int IRQ_N    = 4;

    // mode field commands
    localparam logic [1:0] CMD_NORMAL = 2'b00;
    localparam logic [1:0] CMD_SLEEP  = 2'b01;
    localparam logic [1:0] CMD_STOP   = 2'b10;
    localparam logic [1:0] CMD_SOFT   = 2'b11;
    localparam logic [1:0] WD_CNT_MAX = 2'b10;

    typedef enum logic [2:0] {
        MODE_INIT     = 3'b000,
        MODE_NORMAL   = 3'b001,
        MODE_STOP     = 3'b010,
        MODE_SLEEP    = 3'b011,
        MODE_RESTART  = 3'b100,
        MODE_FAILSAFE = 3'b101
    } rso_mode_e;

    typedef enum logic [1:0] {
        RS_IDLE  = 2'b00,
        RS_HOLD  = 2'b01,
        RS_DELAY = 2'b10
    } rso_rst_e;

endpackage

// file: rso_reset_out.sv
// Purpose : reset output generation, mode tracking and soft reset
// Assumes : undervoltage and watchdog inputs synchronous to I_CLOCK
// Notes   : registers reached over Avalon-MM, one wait cycle per access
`timescale 1ns/1ps

// Functional notes
// RULE_01 - filtered condition pulls reset low, held plus delay
// RULE_02 - extended delay default, reduced when select set
// RULE_03 - power-up holds low, extended delay then release
// RULE_04 - watchdog failure also asserts the reset output
// RULE_05 - threshold select writable, resets to lowest setting
// RULE_06 - mode 11 soft reset: init mode, defaults
// RULE_07 - pulse option 0: reset output, extended delay
// RULE_08 - pulse option 1: internal reinit, no reset
// RULE_09 - soft reset accepted only in normal, stop
// RULE_10 - watchdog reset: restart or fail-safe, count failures
// RULE_11 - release after watchdog: long window, normal mode
// RULE_12 - locked gpio config kept, timer/pwm restored
// RULE_13 - soft reset acts only after frame ends
module rso_reset_out #(
    parameter logic [rso_pkg::DLY_W-1:0] EXT_DELAY = rso_pkg::DLY_W'(rso_pkg::EXT_DELAY_CYCLES),
    parameter logic [rso_pkg::DLY_W-1:0] RED_DELAY = rso_pkg::DLY_W'(rso_pkg::RED_DELAY_CYCLES)
) (
    input  wire logic        I_CLOCK,            // 40 MHz clock
    input  wire logic        I_RST_N,            // sync reset, active low
    input  wire logic        I_UNDERVOLTAGE,     // regulator below threshold
    input  wire logic        I_WATCHDOG_FAILURE_COUNT,          // watchdog trigger failure pulse
    input  wire logic [4:0]  I_AVS_ADDRESS,      // byte address
    input  wire logic        I_AVS_READ,         // read request
    input  wire logic        I_AVS_WRITE,        // write request
    input  wire logic [31:0] I_AVS_WRITEDATA,    // write data
    input  wire logic [3:0]  I_AVS_BYTEENABLE,   // byte lanes
    output logic [31:0]      O_AVS_READDATA,     // read data
    output logic             O_AVS_WAITREQUEST,  // stall
    output logic             O_RESET_OUT_N,      // reset to host, active low
    output logic             O_IRQ,              // level interrupt
    output logic [2:0]       O_MODE,             // current device mode
    output logic             O_WD_LONG_WINDOW,   // start long open window pulse
    output logic [1:0]       O_UV_THRESHOLD,     // undervoltage threshold select
    output logic [2:0]       O_GPIO_CFG,         // gpio configuration
    output logic [7:0]       O_TIMER_PWM         // timer / pwm setting
);

    // ****************************************************************
    // bus slave
    // ****************************************************************
    logic        req;
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        wr_en;

    assign req               = I_AVS_READ || I_AVS_WRITE;
    assign O_AVS_WAITREQUEST = req && !ack_q;
    assign wr_en             = I_AVS_WRITE && ack_q && I_AVS_BYTEENABLE[0];
    assign O_AVS_READDATA    = rdata_q;

    rso_pkg::rso_mode_e mode_q;
    rso_pkg::rso_mode_e mode_d;
    rso_pkg::rso_rst_e  rst_q;
    rso_pkg::rso_rst_e  rst_d;
    logic [5:0]                    cfg_q;
    logic [5:0]                    cfg_d;
    logic [2:0]                    gpio_q;
    logic [2:0]                    gpio_d;
    logic [7:0]                    tpwm_q;
    logic [7:0]                    tpwm_d;
    logic [1:0]                    wdcnt_q;
    logic [1:0]                    wdcnt_d;
    logic [rso_pkg::IRQ_N-1:0]     irq_st_q;
    logic [rso_pkg::IRQ_N-1:0]     irq_st_d;
    logic [rso_pkg::IRQ_N-1:0]     irq_mk_q;
    logic [rso_pkg::IRQ_N-1:0]     irq_mk_d;
    logic [rso_pkg::IRQ_N-1:0]     irq_ev;
    logic                          pend_q;
    logic                          pend_d;
    logic                          wdrst_q;
    logic                          wdrst_d;
    logic                          rstout_q;
    logic                          rstout_d;
    logic [rso_pkg::FILT_W-1:0]    filt_q;
    logic [rso_pkg::FILT_W-1:0]    filt_d;
    logic                          soft_exec;
    logic                          soft_cmd;
    logic                          filt_hit;
    logic                          release_ev;
    logic                          tmr_load;
    logic [rso_pkg::DLY_W-1:0]     tmr_val;
    logic                          tmr_done;

    always_comb begin
        ack_d   = req && !ack_q;
        rdata_d = rdata_q;
        if (req && !ack_q) begin
            rdata_d = 32'h0000_0000;
            if (I_AVS_ADDRESS == rso_pkg::OFS_MODE_CTRL) begin
                rdata_d = {29'h0000_0000, mode_q};
            end else if (I_AVS_ADDRESS == rso_pkg::OFS_RESET_CFG) begin
                rdata_d = {26'h000_0000, cfg_q};
            end else if (I_AVS_ADDRESS == rso_pkg::OFS_STATUS) begin
                rdata_d = {29'h0000_0000, rstout_q, wdcnt_q};
            end else if (I_AVS_ADDRESS == rso_pkg::OFS_GPIO_CFG) begin
                rdata_d = {29'h0000_0000, gpio_q};
            end else if (I_AVS_ADDRESS == rso_pkg::OFS_TIMER_PWM) begin
                rdata_d = {24'h00_0000, tpwm_q};
            end else if (I_AVS_ADDRESS == rso_pkg::OFS_IRQ_STAT) begin
                rdata_d = {28'h000_0000, irq_st_q};
            end else if (I_AVS_ADDRESS == rso_pkg::OFS_IRQ_MASK) begin
                rdata_d = {28'h000_0000, irq_mk_q};
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    // soft reset restores defaults, but a locked gpio setup survives it
    always_comb begin
        cfg_d  = cfg_q;
        gpio_d = gpio_q;
        tpwm_d = tpwm_q;
        if (soft_exec) begin
            cfg_d  = rso_pkg::RESET_CFG_RST;                          // [RULE_06] [RULE_05]
            tpwm_d = rso_pkg::TIMER_PWM_RST;                          // [RULE_12]
            if (cfg_q[rso_pkg::CFG_LOCK]) begin
                cfg_d[rso_pkg::CFG_LOCK] = 1'b1;                      // [RULE_12]
            end else begin
                gpio_d = rso_pkg::GPIO_CFG_RST;
            end
        end else if (wr_en) begin
            if (I_AVS_ADDRESS == rso_pkg::OFS_RESET_CFG) begin
                cfg_d = I_AVS_WRITEDATA[5:0];                         // [RULE_02] [RULE_05]
            end else if (I_AVS_ADDRESS == rso_pkg::OFS_GPIO_CFG && !cfg_q[rso_pkg::CFG_LOCK]) begin
                gpio_d = I_AVS_WRITEDATA[2:0];
            end else if (I_AVS_ADDRESS == rso_pkg::OFS_TIMER_PWM) begin
                tpwm_d = I_AVS_WRITEDATA[7:0];
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            cfg_q  <= rso_pkg::RESET_CFG_RST;
            gpio_q <= rso_pkg::GPIO_CFG_RST;
            tpwm_q <= rso_pkg::TIMER_PWM_RST;
        end else begin
            cfg_q  <= cfg_d;
            gpio_q <= gpio_d;
            tpwm_q <= tpwm_d;
        end
    end

    // ****************************************************************
    // mode, soft reset command and reset output
    // ****************************************************************
    assign soft_cmd   = wr_en && (I_AVS_ADDRESS == rso_pkg::OFS_MODE_CTRL)
                        && (I_AVS_WRITEDATA[1:0] == rso_pkg::CMD_SOFT)
                        && (mode_q == rso_pkg::MODE_NORMAL || mode_q == rso_pkg::MODE_STOP);
    // waiting for the request to drop keeps the register port quiet meanwhile
    assign soft_exec  = pend_q && !req;                               // [RULE_13]
    assign filt_hit   = I_UNDERVOLTAGE && (filt_q == rso_pkg::FILT_W'(rso_pkg::FILTER_CYCLES - 1));
    assign release_ev = (rst_q == rso_pkg::RS_DELAY) && tmr_done && !I_UNDERVOLTAGE && !tmr_load;

    always_comb begin
        mode_d   = mode_q;
        rst_d    = rst_q;
        pend_d   = pend_q;
        wdrst_d  = wdrst_q;
        rstout_d = rstout_q;
        wdcnt_d  = wdcnt_q;
        filt_d   = '0;
        tmr_load = 1'b0;
        tmr_val  = cfg_q[rso_pkg::CFG_DLY_SEL] ? RED_DELAY : EXT_DELAY; // [RULE_02]
        if (soft_cmd) begin
            pend_d = 1'b1;                                            // [RULE_09]
        end else if (soft_exec) begin
            pend_d = 1'b0;
        end
        if (wr_en && I_AVS_ADDRESS == rso_pkg::OFS_MODE_CTRL && I_AVS_WRITEDATA[1:0] != rso_pkg::CMD_SOFT
            && (mode_q == rso_pkg::MODE_INIT || mode_q == rso_pkg::MODE_NORMAL
                || mode_q == rso_pkg::MODE_STOP)) begin
            case (I_AVS_WRITEDATA[1:0])
                rso_pkg::CMD_STOP:  mode_d = rso_pkg::MODE_STOP;
                rso_pkg::CMD_SLEEP: mode_d = rso_pkg::MODE_SLEEP;
                default:            mode_d = rso_pkg::MODE_NORMAL;
            endcase
        end
        case (rst_q)
            rso_pkg::RS_IDLE: begin
                rstout_d = 1'b0;
                if (I_UNDERVOLTAGE) begin
                    filt_d = filt_q + 1'b1;
                end
                if (filt_hit) begin
                    rst_d    = rso_pkg::RS_HOLD;                      // [RULE_01]
                    rstout_d = 1'b1;
                end
            end
            rso_pkg::RS_HOLD: begin
                if (!I_UNDERVOLTAGE) begin
                    rst_d    = rso_pkg::RS_DELAY;                     // [RULE_01] [RULE_03]
                    tmr_load = 1'b1;
                    if (!wdrst_q && mode_q == rso_pkg::MODE_INIT) begin
                        tmr_val = EXT_DELAY;                          // [RULE_03]
                    end
                end
            end
            default: begin
                if (I_UNDERVOLTAGE) begin
                    rst_d = rso_pkg::RS_HOLD;                         // [RULE_01]
                end else if (tmr_done) begin
                    rst_d    = rso_pkg::RS_IDLE;
                    rstout_d = 1'b0;
                    if (wdrst_q && mode_q == rso_pkg::MODE_RESTART) begin
                        mode_d = rso_pkg::MODE_NORMAL;                // [RULE_11]
                    end
                    wdrst_d = 1'b0;
                end
            end
        endcase
        if (soft_exec) begin
            mode_d  = rso_pkg::MODE_INIT;                             // [RULE_06]
            wdcnt_d = 2'b00;
            wdrst_d = 1'b0;
            if (!cfg_q[rso_pkg::CFG_NOPULSE]) begin                   // [RULE_08]
                rst_d    = rso_pkg::RS_DELAY;                         // [RULE_07]
                rstout_d = 1'b1;
                tmr_load = 1'b1;
                tmr_val  = EXT_DELAY;
            end
        end
        if (I_WATCHDOG_FAILURE_COUNT) begin
            mode_d   = cfg_q[rso_pkg::CFG_FAILSAFE] ? rso_pkg::MODE_FAILSAFE
                                                    : rso_pkg::MODE_RESTART; // [RULE_10]
            wdrst_d  = 1'b1;
            rstout_d = 1'b1;                                          // [RULE_04]
            if (wdcnt_q != rso_pkg::WD_CNT_MAX) begin
                wdcnt_d = wdcnt_q + 1'b1;                             // [RULE_10]
            end
            if (rst_q != rso_pkg::RS_HOLD || !I_UNDERVOLTAGE) begin
                rst_d    = rso_pkg::RS_DELAY;
                tmr_load = 1'b1;
                tmr_val  = cfg_q[rso_pkg::CFG_DLY_SEL] ? RED_DELAY : EXT_DELAY;
            end
        end
    end

    // power-up: output low in hold until the regulator is good
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            mode_q   <= rso_pkg::MODE_INIT;
            rst_q    <= rso_pkg::RS_HOLD;                             // [RULE_03]
            pend_q   <= 1'b0;
            wdrst_q  <= 1'b0;
            rstout_q <= 1'b1;
            wdcnt_q  <= 2'b00;
            filt_q   <= '0;
        end else begin
            mode_q   <= mode_d;
            rst_q    <= rst_d;
            pend_q   <= pend_d;
            wdrst_q  <= wdrst_d;
            rstout_q <= rstout_d;
            wdcnt_q  <= wdcnt_d;
            filt_q   <= filt_d;
        end
    end

    rso_timer u_delay (
        .I_CLOCK (I_CLOCK),
        .I_RST_N (I_RST_N),
        .i_load  (tmr_load),
        .i_value (tmr_val),
        .o_done  (tmr_done)
    );

    // ****************************************************************
    // interrupts
    // ****************************************************************
    assign irq_ev[rso_pkg::IRQ_UV]   = filt_hit && (rst_q == rso_pkg::RS_IDLE);
    assign irq_ev[rso_pkg::IRQ_WD]   = I_WATCHDOG_FAILURE_COUNT;
    assign irq_ev[rso_pkg::IRQ_SOFT] = soft_exec;
    assign irq_ev[rso_pkg::IRQ_REL]  = release_ev;

    // event set beats a write-one clear in the same cycle
    always_comb begin
        irq_st_d = irq_st_q;
        irq_mk_d = irq_mk_q;
        if (wr_en && I_AVS_ADDRESS == rso_pkg::OFS_IRQ_STAT) begin
            irq_st_d = irq_st_q & ~I_AVS_WRITEDATA[rso_pkg::IRQ_N-1:0];
        end
        if (wr_en && I_AVS_ADDRESS == rso_pkg::OFS_IRQ_MASK) begin
            irq_mk_d = I_AVS_WRITEDATA[rso_pkg::IRQ_N-1:0];
        end
        irq_st_d = irq_st_d | irq_ev;
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            irq_st_q <= '0;
            irq_mk_q <= '0;
        end else begin
            irq_st_q <= irq_st_d;
            irq_mk_q <= irq_mk_d;
        end
    end

    assign O_IRQ            = |(irq_st_q & irq_mk_q);
    assign O_RESET_OUT_N    = !rstout_q;
    assign O_MODE           = mode_q;
    assign O_WD_LONG_WINDOW = release_ev;                             // [RULE_11]
    assign O_UV_THRESHOLD   = cfg_q[rso_pkg::CFG_THR_LO+1:rso_pkg::CFG_THR_LO];
    assign O_GPIO_CFG       = gpio_q;
    assign O_TIMER_PWM      = tpwm_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    sequence s_wd_event;
        I_WATCHDOG_FAILURE_COUNT && !cfg_q[rso_pkg::CFG_FAILSAFE];
    endsequence
    sequence s_restart_held;
        !O_RESET_OUT_N && mode_q == rso_pkg::MODE_RESTART;
    endsequence

    filter_assert_a: assert property (filt_hit && rst_q == rso_pkg::RS_IDLE |=> !O_RESET_OUT_N) // [RULE_01]
        else $error("reset not asserted after filter time");
    filter_early_a: assert property (rst_q == rso_pkg::RS_IDLE && !filt_hit && !I_WATCHDOG_FAILURE_COUNT
                                     && !(soft_exec && !cfg_q[rso_pkg::CFG_NOPULSE])
                                     |=> O_RESET_OUT_N) // [RULE_01]
        else $error("reset asserted before filter time");
    uv_hold_a: assert property (!O_RESET_OUT_N && I_UNDERVOLTAGE |=> !O_RESET_OUT_N) // [RULE_01]
        else $error("reset released while undervoltage present");
    delay_sel_a: assert property (tmr_load && tmr_val == RED_DELAY && RED_DELAY != EXT_DELAY
                                  |-> cfg_q[rso_pkg::CFG_DLY_SEL]) // [RULE_02]
        else $error("reduced delay used without select bit");
    powerup_low_a: assert property (!O_RESET_OUT_N && mode_q == rso_pkg::MODE_INIT && !wdrst_q
                                    && rst_q == rso_pkg::RS_HOLD && !I_UNDERVOLTAGE
                                    |=> tmr_load == 1'b0 ##0 !O_RESET_OUT_N) // [RULE_03]
        else $error("power-up release without delay");
    wd_mode_a: assert property (s_wd_event |=> !O_RESET_OUT_N ##0 s_restart_held) // [RULE_04]
        else $error("watchdog failure did not reset into restart");
    wd_count_a: assert property (I_WATCHDOG_FAILURE_COUNT && wdcnt_q == 2'b00 |=> wdcnt_q == 2'b01) // [RULE_10]
        else $error("watchdog failure count not updated");
    soft_pulse_a: assert property (soft_exec && !cfg_q[rso_pkg::CFG_NOPULSE] && !I_WATCHDOG_FAILURE_COUNT
                                   |=> !O_RESET_OUT_N && mode_q == rso_pkg::MODE_INIT
                                   && cfg_q[rso_pkg::CFG_DLY_SEL] == 1'b0) // [RULE_07]
        else $error("soft reset did not pulse the reset output");
    soft_quiet_a: assert property (soft_exec && cfg_q[rso_pkg::CFG_NOPULSE] && O_RESET_OUT_N
                                   && !I_WATCHDOG_FAILURE_COUNT && !filt_hit |=> O_RESET_OUT_N) // [RULE_08]
        else $error("soft reset pulsed reset output");
    soft_gate_a: assert property (wr_en && I_AVS_ADDRESS == rso_pkg::OFS_MODE_CTRL
                                  && I_AVS_WRITEDATA[1:0] == rso_pkg::CMD_SOFT && !pend_q
                                  && mode_q != rso_pkg::MODE_NORMAL
                                  && mode_q != rso_pkg::MODE_STOP |=> !pend_q) // [RULE_09]
        else $error("soft reset accepted outside normal or stop");
    soft_frame_a: assert property (soft_cmd |=> pend_q && mode_q != rso_pkg::MODE_INIT) // [RULE_13]
        else $error("soft reset executed during a bus transfer");
    wd_release_a: assert property (release_ev && wdrst_q && mode_q == rso_pkg::MODE_RESTART
                                   && !soft_exec && !I_WATCHDOG_FAILURE_COUNT
                                   |=> mode_q == rso_pkg::MODE_NORMAL && O_RESET_OUT_N) // [RULE_11]
        else $error("no normal mode after watchdog reset release");
    lock_keep_a: assert property (soft_exec && cfg_q[rso_pkg::CFG_LOCK]
                                  |=> $stable(gpio_q) && tpwm_q == rso_pkg::TIMER_PWM_RST) // [RULE_12]
        else $error("soft reset handling of gpio or timer wrong");

endmodule // rso_reset_out

// file: rso_reset_out_tb_top.sv
// Purpose: bench for the reset output block
// Assumes: delays shortened to 40 and 10 cycles
// Notes  : bus calls hold until waitrequest low
`timescale 1ns/1ps
module rso_reset_out_tb_top;
    localparam int EXT = 40;
    localparam int RED = 10;
    localparam logic [4:0] A_MD = rso_pkg::OFS_MODE_CTRL;
    localparam logic [4:0] A_CFG = rso_pkg::OFS_RESET_CFG;
    logic clk = 0, rst_n = 0, uv = 1, wdf = 0, rd = 0, wr = 0, wq, ro_n, irq, lw;
    logic [4:0] adr = 0;
    logic [31:0] wd = 0, rdat, rdv;
    logic [2:0] mode, gpio;
    logic [1:0] thr;
    logic [7:0] tpwm;
    int n_fail = 0, checked = 0, cyc = 0, pulses, len, n, lwn;
    always #12.5 clk = ~clk;
    rso_reset_out #(.EXT_DELAY(20'(EXT)), .RED_DELAY(20'(RED))) uut (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_UNDERVOLTAGE(uv), .I_WATCHDOG_FAILURE_COUNT(wdf),
        .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
        .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq),
        .O_RESET_OUT_N(ro_n), .O_IRQ(irq), .O_MODE(mode), .O_WD_LONG_WINDOW(lw),
        .O_UV_THRESHOLD(thr), .O_GPIO_CFG(gpio), .O_TIMER_PWM(tpwm));
    rso_host host (.I_CLOCK(clk), .i_rst_n(ro_n), .o_pulses(pulses), .o_len(len));
    task automatic summarize();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    // ranged delays: on a miss the low bound is shown as expected
    task automatic rng(string s, int lo, int hi, int g);
        chk(s, (g >= lo && g <= hi) ? g : lo, g);
    endtask
    task automatic acc(logic w, logic [4:0] a, logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wq !== 1'b0);
        rdv = rdat;
        rd <= 0;
        wr <= 0;
        @(posedge clk);
    endtask
    task automatic hi(output int k);
        k = 0;
        lwn = 0;
        while (ro_n !== 1'b1) begin
            @(posedge clk);
            k++;
            if (lw === 1'b1) lwn++;
        end
    endtask
    task automatic uvev(int d);
        @(posedge clk);
        uv <= 1;
        repeat (rso_pkg::FILTER_CYCLES - 1) @(posedge clk);
        chk("filt_hi", 1, ro_n);
        repeat (3) @(posedge clk);
        chk("filt_lo", 0, ro_n);
        uv <= 0;
        hi(n);
        rng("uv_dly", d, d + 3, n);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        repeat (5) @(posedge clk);
        chk("pwr_hold", 0, ro_n);
        uv <= 0;
        hi(n);
        rng("pwr_dly", EXT, EXT + 3, n);
        acc(0, A_CFG, 0);
        chk("cfg_rst", 0, rdv);
        acc(1, A_MD, 0);
        uvev(EXT);
        acc(0, rso_pkg::OFS_IRQ_STAT, 0);
        chk("irq_stat", 32'h0000_0009, rdv);
        chk("irq_off", 0, irq);
        acc(1, rso_pkg::OFS_IRQ_MASK, 1);
        chk("irq_on", 1, irq);
        acc(1, rso_pkg::OFS_IRQ_STAT, 32'h0000_0009);
        chk("irq_clr", 0, irq);
        acc(0, 5'h1C, 0);
        chk("unmapped", 0, rdv);
        $display("test undervoltage done");
        acc(1, A_CFG, 32'h0000_0007);
        chk("thr", 3, thr);
        uvev(RED);
        acc(1, A_MD, 0);
        wdf <= 1;
        @(posedge clk);
        wdf <= 0;
        @(posedge clk);
        chk("wd_rst", 0, ro_n);
        chk("restart", rso_pkg::MODE_RESTART, mode);
        hi(n);
        @(posedge clk);
        chk("wd_norm", rso_pkg::MODE_NORMAL, mode);
        rng("wd_len", RED, RED + 3, len);
        chk("wd_lw", 1, lwn);
        acc(0, rso_pkg::OFS_STATUS, 0);
        chk("wd_cnt", 1, rdv);
        $display("test watchdog done");
        acc(1, rso_pkg::OFS_GPIO_CFG, 5);
        acc(1, rso_pkg::OFS_TIMER_PWM, 32'h0000_005A);
        acc(1, A_CFG, 32'h0000_0026);
        acc(1, A_MD, 2);
        acc(1, A_MD, 3);
        repeat (2) @(posedge clk);
        chk("soft_rst", 0, ro_n);
        chk("soft_init", rso_pkg::MODE_INIT, mode);
        hi(n);
        @(posedge clk);
        rng("soft_len", EXT, EXT + 3, len);
        chk("gpio_kept", 5, gpio);
        chk("pwm_clr", 0, tpwm);
        acc(0, A_CFG, 0);
        chk("cfg_def", 32'h0000_0020, rdv);
        acc(1, A_MD, 0);
        acc(1, A_CFG, 32'h0000_0008);
        n = pulses;
        acc(1, A_MD, 3);
        repeat (4) @(posedge clk);
        chk("np_init", rso_pkg::MODE_INIT, mode);
        chk("np_pulse", n, pulses);
        acc(1, A_MD, 0);
        acc(1, A_MD, 1);
        acc(1, A_MD, 3);
        repeat (4) @(posedge clk);
        chk("sleep_kept", rso_pkg::MODE_SLEEP, mode);
        $display("test soft reset done");
        acc(1, A_CFG, 32'h0000_0010);
        wdf <= 1;
        @(posedge clk);
        wdf <= 0;
        @(posedge clk);
        chk("failsafe", rso_pkg::MODE_FAILSAFE, mode);
        hi(n);
        @(posedge clk);
        chk("fs_kept", rso_pkg::MODE_FAILSAFE, mode);
        acc(0, rso_pkg::OFS_IRQ_STAT, 0);
        chk("irq_all", 32'h0000_000F, rdv);
        $display("test failsafe done");
        summarize();
    end
endmodule // rso_reset_out_tb_top

// file: rso_timer.sv
// Purpose : loadable down counter timing the reset delay
// Assumes : load has priority over counting
// Notes   : o_done is high while the count is zero, a same-cycle load is the caller's to mask
`timescale 1ns/1ps
module rso_timer (
    input  wire logic                    I_CLOCK,   // system clock
    input  wire logic                    I_RST_N,   // sync reset, active low
    input  wire logic                    i_load,    // start a new delay
    input  wire logic [rso_pkg::DLY_W-1:0] i_value, // delay in cycles
    output logic                         o_done     // delay expired
);
    logic [rso_pkg::DLY_W-1:0] cnt_q;
    logic [rso_pkg::DLY_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (i_load) begin
            cnt_d = i_value;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // no path from i_load: the caller masks a same-cycle load by combining this flag with its own load
    assign o_done = (cnt_q == '0);

endmodule // rso_timer
